// >>> apb_peripheral_write_protect.v
`timescale 1ns/1ps
`include "apb_wp_defs.vh"

module apb_peripheral_write_protect (
    input  wire        i_clk,
    input  wire        i_rst_n,
    input  wire        i_ce,
    input  wire        i_hsel,
    input  wire [31:0] i_haddr,
    input  wire [1:0]  i_htrans,
    input  wire        i_hwrite,
    input  wire [2:0]  i_hsize,
    input  wire [3:0]  i_hprot,
    input  wire [31:0] i_hwdata,
    input  wire        i_hready,
    output wire        o_hreadyout,
    output wire        o_hresp,
    output wire [31:0] o_hrdata,
    output wire [31:0] o_paddr,
    output wire        o_psel,
    output wire        o_penable,
    output wire        o_pwrite,
    output wire [31:0] o_pwdata,
    output wire [3:0]  o_pstrb,
    output wire [2:0]  o_pprot,
    input  wire [31:0] i_prdata,
    input  wire        i_pready,
    input  wire        i_pslverr,
    output wire [31:0] o_wp_group1,
    output wire [31:0] o_wp_group2,
    output wire [31:0] o_wp_group3
);
    localparam [6:0] S_IDLE   = 7'b000_0001;
    localparam [6:0] S_LATCH  = 7'b000_0010;
    localparam [6:0] S_INT    = 7'b000_0100;
    localparam [6:0] S_SETUP  = 7'b000_1000;
    localparam [6:0] S_ACCESS = 7'b001_0000;
    localparam [6:0] S_ERR1   = 7'b010_0000;
    localparam [6:0] S_ERR2   = 7'b100_0000;

    reg  [6:0]  state_ff;
    reg  [6:0]  nxt_state;
    reg  [31:0] addr_ff;
    reg         write_ff;
    reg  [3:0]  strb_ff;
    reg  [2:0]  prot_ff;
    reg  [31:0] wdata_ff;
    reg  [31:0] rdata_ff;
    reg  [3:0]  nxt_strb;
    reg  [31:0] grp_state;
    reg         grp_valid;

    wire        take;
    wire [1:0]  grp;
    wire [4:0]  slot;
    wire        is_ctrl;
    wire        blocked;
    wire        int_wr;
    wire        ofs_ok;
    wire [31:0] grp1_state;
    wire [31:0] grp2_state;
    wire [31:0] grp3_state;

    // New transfer accepted only when the previous data phase ends
    assign take = i_hsel & i_htrans[`HTRANS_ACTIVE_BIT] & i_hready
                & (state_ff[0] | state_ff[6]);

    // Lane strobes from size and low address, kept for reads too
    always @*
    begin
        case (i_hsize)
            `HSIZE_BYTE: nxt_strb = `STRB_BYTE0 << i_haddr[1:0];
            `HSIZE_HALF: nxt_strb = i_haddr[1] ? `STRB_HALF_HI : `STRB_HALF_LO;
            default:     nxt_strb = `STRB_WORD;
        endcase
    end

    assign grp     = addr_ff[`WP_GRP_MSB:`WP_GRP_LSB];
    assign slot    = addr_ff[`WP_SLOT_MSB:`WP_SLOT_LSB];
    assign is_ctrl = (slot == `WP_CTRL_SLOT);

    always @*
    begin
        grp_valid = 1'b1;
        case (grp)
            `WP_GRP1: grp_state = grp1_state;
            `WP_GRP2: grp_state = grp2_state;
            `WP_GRP3: grp_state = grp3_state;
            default:
            begin
                grp_state = 32'h0000_0000;
                grp_valid = 1'b0;
            end
        endcase
    end

    // Protected slot: the write never reaches the peripheral
    assign blocked = write_ff & grp_state[slot];
    assign int_wr  = state_ff[2] & write_ff & grp_valid;
    // Only the clear and set offsets exist; others read as zero
    assign ofs_ok  = (addr_ff[`WP_OFS_MSB:0] == `WP_OFS_CLEAR)
                   | (addr_ff[`WP_OFS_MSB:0] == `WP_OFS_SET);

    always @*
    begin
        case (state_ff)
            S_IDLE:   nxt_state = take ? S_LATCH : S_IDLE;
            S_LATCH:
            begin
                if (!grp_valid)
                    nxt_state = S_ERR1;
                else if (is_ctrl)
                    nxt_state = S_INT;
                else if (blocked)
                    nxt_state = S_ERR1;
                else
                    nxt_state = S_SETUP;
            end
            S_INT:    nxt_state = S_IDLE;
            S_SETUP:  nxt_state = S_ACCESS;
            S_ACCESS: nxt_state = !i_pready ? S_ACCESS
                                : (i_pslverr ? S_ERR1 : S_IDLE);
            S_ERR1:   nxt_state = S_ERR2;
            S_ERR2:   nxt_state = take ? S_LATCH : S_IDLE;
            default:  nxt_state = S_IDLE;
        endcase
    end

    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state_ff <= S_IDLE;
            addr_ff  <= 32'h0000_0000;
            write_ff <= 1'b0;
            strb_ff  <= 4'h0;
            prot_ff  <= 3'h0;
            wdata_ff <= 32'h0000_0000;
            rdata_ff <= 32'h0000_0000;
        end
        else if (i_ce)
        begin
            state_ff <= nxt_state;
            if (take)
            begin
                addr_ff  <= i_haddr;
                write_ff <= i_hwrite;
                strb_ff  <= nxt_strb;
                // Privileged into bit 0, data/instr inverted into bit 2
                prot_ff  <= {~i_hprot[0], 1'b0, i_hprot[1]};
            end
            // Data phase: capture so address and data leave together
            if (state_ff[1])
                wdata_ff <= i_hwdata;
            if (state_ff[2])
                rdata_ff <= (write_ff || !grp_valid || !ofs_ok) ? 32'h0000_0000
                          : grp_state;
            if (state_ff[4] && i_pready)
                rdata_ff <= i_prdata;
        end
    end

    wp_group #(.RESET_VAL(`WP_RST_GRP1), .IMPL_MASK(`WP_MASK_GRP1)) u_grp1 (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_wr    (int_wr && grp == `WP_GRP1),
        .i_ofs   (addr_ff[`WP_OFS_MSB:0]),
        .i_wdata (wdata_ff),
        .i_strb  (strb_ff),
        .o_state (grp1_state)
    );

    wp_group #(.RESET_VAL(`WP_RST_GRP2), .IMPL_MASK(`WP_MASK_GRP2)) u_grp2 (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_wr    (int_wr && grp == `WP_GRP2),
        .i_ofs   (addr_ff[`WP_OFS_MSB:0]),
        .i_wdata (wdata_ff),
        .i_strb  (strb_ff),
        .o_state (grp2_state)
    );

    // Bits 1..18: event, six serial, three control, five basic timers, analog
    wp_group #(.RESET_VAL(`WP_RST_GRP3), .IMPL_MASK(`WP_MASK_GRP3)) u_grp3 (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_wr    (int_wr && grp == `WP_GRP3),
        .i_ofs   (addr_ff[`WP_OFS_MSB:0]),
        .i_wdata (wdata_ff),
        .i_strb  (strb_ff),
        .o_state (grp3_state)
    );

    // Two-cycle error answer as the fast bus demands
    assign o_hreadyout = state_ff[0] | state_ff[6];
    assign o_hresp     = state_ff[5] | state_ff[6];
    assign o_hrdata    = rdata_ff;

    assign o_paddr   = addr_ff;
    assign o_psel    = state_ff[3] | state_ff[4];
    assign o_penable = state_ff[4];
    assign o_pwrite  = write_ff;
    assign o_pwdata  = wdata_ff;
    assign o_pstrb   = strb_ff;
    assign o_pprot   = prot_ff;

    assign o_wp_group1 = grp1_state;
    assign o_wp_group2 = grp2_state;
    assign o_wp_group3 = grp3_state;
endmodule // apb_peripheral_write_protect

// >>> apb_wp_defs.vh
`ifndef APB_WP_DEFS_VH
`define APB_WP_DEFS_VH

`define WP_OFS_CLEAR      4'h0
`define WP_OFS_SET        4'h4
`define WP_OFS_MSB        3
`define WP_SLOT_MSB       14
`define WP_SLOT_LSB       10
`define WP_GRP_MSB        17
`define WP_GRP_LSB        16
`define WP_GRP1           2'h0
`define WP_GRP2           2'h1
`define WP_GRP3           2'h2
`define WP_CTRL_SLOT      5'h00

`define WP_RST_GRP1       32'h0000_0000
`define WP_RST_GRP2       32'h0080_0000
`define WP_RST_GRP3       32'h0000_0000
`define WP_MASK_GRP1      32'h0000_001E
`define WP_MASK_GRP2      32'h0080_000E
`define WP_MASK_GRP3      32'h0007_FFFE

`define WP_BIT_WATCHDOG   4
`define WP_BIT_CLOCK_GEN  3
`define WP_BIT_SYS_CTRL   2
`define WP_BIT_POWER_MGR  1
`define WP_BIT_PORT       3
`define WP_BIT_NONVOL     2
`define WP_BIT_SERVICE    1
`define WP_BIT_EVENT_SYS  1
`define WP_BIT_SERIAL0    2
`define WP_BIT_CTRL_TMR0  8
`define WP_BIT_BASIC_TMR0 11
`define WP_BIT_ADC        16
`define WP_BIT_COMPARATOR 17
`define WP_BIT_DAC        18

`define HTRANS_ACTIVE_BIT 1
`define HSIZE_BYTE        3'h0
`define HSIZE_HALF        3'h1
`define STRB_BYTE0        4'h1
`define STRB_HALF_LO      4'h3
`define STRB_HALF_HI      4'hC
`define STRB_WORD         4'hF

`endif

// >>> wp_group.v
`timescale 1ns/1ps
`include "apb_wp_defs.vh"

module wp_group #(
    parameter [31:0] RESET_VAL = 32'h0000_0000,
    parameter [31:0] IMPL_MASK = 32'h0000_0000
) (
    input  wire        i_clk,
    input  wire        i_rst_n,
    input  wire        i_ce,
    input  wire        i_wr,
    input  wire [3:0]  i_ofs,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_strb,
    output wire [31:0] o_state
);
    reg  [31:0] state_ff;
    wire [31:0] lane_mask;
    wire [31:0] hit;
    wire [31:0] nxt_state;

    assign lane_mask = {{8{i_strb[3]}}, {8{i_strb[2]}}, {8{i_strb[1]}}, {8{i_strb[0]}}};
    // Only ones on enabled lanes act; zeros leave state alone
    assign hit = i_wdata & lane_mask & IMPL_MASK;
    assign nxt_state = (i_ofs == `WP_OFS_CLEAR) ? (state_ff & ~hit)
                     : (i_ofs == `WP_OFS_SET)   ? (state_ff | hit)
                     : state_ff;

    always @(posedge i_clk)
    begin
        if (!i_rst_n)
            state_ff <= RESET_VAL;
        else if (i_ce && i_wr)
            state_ff <= nxt_state;
    end

    // Same value at both offsets, 1 means blocked
    assign o_state = state_ff;
endmodule // wp_group

// >>> apb_wp_sva.sv
`timescale 1ns/1ps
module apb_wp_sva (
    input wire        i_clk,
    input wire        i_rst_n,
    input wire        o_hreadyout,
    input wire        o_hresp,
    input wire        o_psel,
    input wire        o_penable,
    input wire [31:0] o_paddr,
    input wire [31:0] o_pwdata,
    input wire [3:0]  o_pstrb,
    input wire        i_pready,
    input wire        i_pslverr,
    input wire [31:0] o_wp_group1
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_wait; o_psel && o_penable && !i_pready; endsequence
    sequence s_done; o_psel && o_penable && i_pready; endsequence
    sequence s_fail; s_done ##0 i_pslverr; endsequence
    property p_en; o_penable |-> o_psel; endproperty
    a_en: assert property (p_en) else $error("penable alone");
    property p_setup; $rose(o_psel) |-> !o_penable ##1 o_penable; endproperty
    a_setup: assert property (p_setup) else $error("no setup cycle");
    property p_hold; s_wait |=> $stable(o_paddr) && $stable(o_pwdata) && o_penable; endproperty
    a_hold: assert property (p_hold) else $error("access not held");
    property p_end; s_done |=> !o_penable; endproperty
    a_end: assert property (p_end) else $error("access not ended");
    property p_err; o_hresp && !o_hreadyout |=> o_hresp && o_hreadyout; endproperty
    a_err: assert property (p_err) else $error("bad error pair");
    property p_slverr; s_fail |-> ##[1:2] o_hresp; endproperty
    a_slverr: assert property (p_slverr) else $error("error lost");
    property p_strb; o_psel |-> o_pstrb != 4'h0; endproperty
    a_strb: assert property (p_strb) else $error("no lane strobe");
    property p_grp; $changed(o_wp_group1) |-> o_hreadyout && !o_psel; endproperty
    a_grp: assert property (p_grp) else $error("stray state change");
    property p_bound; $fell(o_hreadyout) |-> ##[1:40] o_hreadyout; endproperty
    a_bound: assert property (p_bound) else $error("bus stuck");
endmodule // apb_wp_sva

// >>> apb_wp_periph.sv
`timescale 1ns/1ps
module apb_wp_periph (
    input  wire        i_clk,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [31:0] i_paddr,
    input  wire [31:0] i_pwdata,
    input  wire [3:0]  i_pstrb,
    input  wire [3:0]  i_waits,
    output wire [31:0] o_prdata,
    output wire        o_pready,
    output wire        o_pslverr
);
    reg  [31:0] mem_ff = 32'h0;
    reg  [3:0]  cnt_ff = 4'h0;
    integer     k;
    wire        acc = i_psel && i_penable;
    assign o_pready  = acc && (cnt_ff == i_waits);
    assign o_pslverr = o_pready && (i_paddr[9:2] == 8'hFF);
    // Idle bus shows inverted data so a stale copy never passes
    assign o_prdata  = o_pready ? mem_ff : ~mem_ff;
    always @(posedge i_clk)
    begin
        cnt_ff <= (acc && !o_pready) ? cnt_ff + 4'h1 : 4'h0;
        if (o_pready && i_pwrite && !o_pslverr)
            for (k = 0; k < 4; k = k + 1)
                if (i_pstrb[k]) mem_ff[8*k +: 8] <= i_pwdata[8*k +: 8];
    end
endmodule // apb_wp_periph

// >>> apb_peripheral_write_protect_bench.sv
`timescale 1ns/1ps
`include "apb_wp_defs.vh"
module apb_peripheral_write_protect_bench;
    reg         clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    reg  [31:0] haddr = 32'h0, hwdata = 32'h0, rd, rsp, ex;
    reg  [1:0]  htrans = 2'h0;
    reg  [2:0]  hsize = 3'h0;
    reg  [3:0]  waits = 4'h0;
    wire        hrdy, hresp, psel, pen, pwr, prdy, perr;
    wire [31:0] hrdata, paddr, pwdata, prdata, g1, g2, g3;
    wire [3:0]  pstrb;
    wire [2:0]  pprot;
    reg  [31:0] msk [0:2];
    reg  [31:0] rst [0:2];
    integer     error_cnt = 0, checks_done = 0, g, b;
    apb_peripheral_write_protect i_apb_peripheral_write_protect (.i_clk(clk),
        .i_rst_n(rst_n), .i_ce(1'b1), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hprot(4'h3), .i_hwdata(hwdata),
        .i_hready(1'b1), .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
        .o_paddr(paddr), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_pwdata(pwdata),
        .o_pstrb(pstrb), .o_pprot(pprot), .i_prdata(prdata), .i_pready(prdy), .i_pslverr(perr),
        .o_wp_group1(g1), .o_wp_group2(g2), .o_wp_group3(g3));
    apb_wp_periph i_apb_wp_periph (.i_clk(clk), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .i_waits(waits), .o_prdata(prdata), .o_pready(prdy), .o_pslverr(perr));
    function [31:0] grp(input integer x);
        grp = (x == 0) ? g1 : (x == 1) ? g2 : g3;
    endfunction
    function [31:0] at(input integer x, input integer s, input [3:0] o);
        at = {14'h0, x[1:0], 1'h0, s[4:0], 6'h00, o};
    endfunction
    task xfer(input w, input [31:0] a, input [2:0] sz, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= a;
            hsize <= sz;
            @(posedge clk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            n = 0;
            @(posedge clk);
            #1;
            while (hrdy !== 1'b1 && n < 40)
            begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            if (n >= 40)
                error_cnt = error_cnt + 1;
            rd = hrdata;
            rsp = {31'h0, hresp};
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp)
            begin
                error_cnt = error_cnt + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d errors %0d", checks_done, error_cnt);
            if (error_cnt == 0 && checks_done > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    initial
    begin
        forever #25 clk = ~clk;
    end
    initial
    begin
        #200000;
        error_cnt = error_cnt + 1;
        end_of_test;
    end
    initial
    begin
        msk[0] = `WP_MASK_GRP1;
        msk[1] = `WP_MASK_GRP2;
        msk[2] = `WP_MASK_GRP3;
        rst[0] = `WP_RST_GRP1;
        rst[1] = `WP_RST_GRP2;
        rst[2] = `WP_RST_GRP3;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (g = 0; g < 3; g = g + 1)
        begin
            xfer(1'b0, at(g, 0, 4'h0), 3'h2, 32'h0);
            chk(rd, rst[g]);
            xfer(1'b0, at(g, 0, 4'h4), 3'h2, 32'h0);
            chk(rd, rst[g]);
        end
        $display("reset test done");
        for (g = 0; g < 3; g = g + 1)
        begin
            ex = msk[g];
            xfer(1'b1, at(g, 0, 4'h4), 3'h2, 32'hFFFF_FFFF);
            chk(grp(g), ex);
            xfer(1'b1, at(g, 0, 4'h0), 3'h2, 32'h0);
            chk(grp(g), ex);
            for (b = 0; b < 32; b = b + 1)
                if (msk[g][b])
                begin
                    xfer(1'b1, at(g, b, 4'h0), 3'h2, b);
                    chk(rsp, 32'h1);
                    ex[b] = 1'b0;
                    xfer(1'b1, at(g, 0, 4'h0), 3'h2, 32'h1 << b);
                    chk(grp(g), ex);
                    xfer(1'b1, at(g, b, 4'h0), 3'h2, b);
                    chk(rsp, 32'h0);
                end
            xfer(1'b0, at(g, 0, 4'h4), 3'h2, 32'h0);
            chk(rd, ex);
        end
        $display("guard test done");
        xfer(1'b1, at(2, 1, 4'h0), 3'h2, 32'h1111_1111);
        xfer(1'b1, at(2, 1, 4'h2), 3'h0, 32'h00AB_0000);
        xfer(1'b1, at(2, 1, 4'h0), 3'h1, 32'h0000_CDEF);
        xfer(1'b0, at(2, 1, 4'h1), 3'h0, 32'h0);
        chk(rd, 32'h11AB_CDEF);
        waits <= 4'h3;
        xfer(1'b0, at(2, 1, 4'h0), 3'h2, 32'h0);
        chk(rd, 32'h11AB_CDEF);
        chk(pprot, 32'h1);
        xfer(1'b1, at(2, 1, 4'hC) | 32'h3F0, 3'h2, 32'h0);
        chk(rsp, 32'h1);
        waits <= 4'h0;
        xfer(1'b1, 32'h0003_0400, 3'h2, 32'h0);
        chk(rsp, 32'h1);
        xfer(1'b1, at(0, 0, 4'h4), 3'h2, 32'h2);
        xfer(1'b1, at(0, 0, 4'h8), 3'h2, 32'hFFFF_FFFF);
        xfer(1'b0, at(0, 0, 4'h8), 3'h2, 32'h0);
        chk(rd, 32'h0);
        chk(g1, 32'h2);
        $display("bridge test done");
        end_of_test;
    end
endmodule // apb_peripheral_write_protect_bench
bind apb_peripheral_write_protect apb_wp_sva i_apb_wp_sva (.i_clk, .i_rst_n, .o_hreadyout,
    .o_hresp, .o_psel, .o_penable, .o_paddr, .o_pwdata, .o_pstrb, .i_pready, .i_pslverr,
    .o_wp_group1);
